/* core/gsr_pkg.sv */
// Shared constants and types for the gyro serial configuration and readout port.
package gsr_pkg;

  // Configuration register layout.
  localparam int          CFG_W        = 12;
  localparam int          WRITE_BIT    = 11;
  localparam int          CHAN_SEL_HI  = 7;
  localparam int          CHAN_SEL_LO  = 6;
  localparam int          CODING_BIT   = 0;
  localparam logic [11:0] CFG_RESET    = 12'h000;

  // Frame timing, in falling serial clock edges counted from chip select low.
  localparam int         FRAME_LEN     = 16;
  localparam logic [4:0] CFG_LAST_EDGE = 5'h0c;
  localparam logic [4:0] DATA_EDGE     = 5'h04;
  localparam logic [4:0] MUX_EDGE      = 5'h0e;
  localparam logic [4:0] LAST_EDGE     = 5'h10;

  // Result width and buffer depth.
  localparam int RES_W     = 12;
  localparam int BUF_DEPTH = 2;

  // Output coding values of the coding bit.
  localparam logic CODE_TWOS     = 1'b0;
  localparam logic CODE_STRAIGHT = 1'b1;

  // Converter input channels.
  typedef enum logic [1:0] {
    CH_RATE  = 2'b00,
    CH_TEMP  = 2'b01,
    CH_AUX_A = 2'b10,
    CH_AUX_B = 2'b11
  } gsr_chan_t;

  // Frame sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_XFER = 2'b01,
    ST_TAIL = 2'b10
  } gsr_state_t;

endpackage

/* core/gsr_buf.sv */
// Two-entry valid/ready buffer for converter results.
`timescale 1ns/1ps
module gsr_buf
  import gsr_pkg::*;
#(
  parameter int W = RES_W
) (
  // Clock and reset.
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // Filling side.
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // Draining side.
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);

  logic [W-1:0] mem_q [BUF_DEPTH];
  logic [W-1:0] mem_d [BUF_DEPTH];
  logic         wr_q, wr_d, rd_q, rd_d;
  logic [1:0]   cnt_q, cnt_d;
  logic         rdy_q, rdy_d;
  logic         push, pop;

  assign push      = in_valid && rdy_q;
  assign pop       = out_ready && (cnt_q != 2'h0);
  assign in_ready  = rdy_q;
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rd_q];

  always_comb begin
    mem_d = mem_q;
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = in_data;
      wr_d        = ~wr_q;
    end
    if (pop) begin
      rd_d = ~rd_q;
    end
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    // Ready is registered, so it may lag a pop by one cycle; nothing is lost.
    rdy_d = (cnt_d != 2'h2);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < BUF_DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      cnt_q <= 2'h0;
      rdy_q <= 1'b1;
    end else begin
      mem_q <= mem_d;
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
      rdy_q <= rdy_d;
    end
  end

endmodule

/* core/gsr_port.sv */
// Serial configuration and readout port of a yaw-rate sensor converter.
`timescale 1ns/1ps
module gsr_port
  import gsr_pkg::*;
(
  // System clock and reset.
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // Serial pins from the host.
  input  wire logic             cs_n,
  input  wire logic             sclk,
  input  wire logic             din,
  // Serial output pin, as two signals: data and output enable.
  output logic                  dout_o,
  output logic                  dout_oe,
  // Converter control.
  output logic [1:0]            mux_sel,
  output logic                  conv_start,
  output logic                  conv_tick,
  // Converter results, straight binary.
  input  wire logic             res_valid,
  input  wire logic [RES_W-1:0] res_data,
  output logic                  res_ready
);

  // Two-stage synchronisers plus one history stage for edge detection.
  logic [2:0] cs_sync_q, sclk_sync_q;
  logic [1:0] din_sync_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cs_sync_q   <= 3'h7;
      sclk_sync_q <= 3'h7;
      din_sync_q  <= 2'h0;
    end else begin
      cs_sync_q   <= {cs_sync_q[1:0], cs_n};
      sclk_sync_q <= {sclk_sync_q[1:0], sclk};
      din_sync_q  <= {din_sync_q[0], din};
    end
  end

  logic cs_fall, cs_high, sclk_fall, din_s;
  assign cs_fall   = cs_sync_q[2] && !cs_sync_q[1];
  assign cs_high   = cs_sync_q[1];
  assign sclk_fall = sclk_sync_q[2] && !sclk_sync_q[1];
  assign din_s     = din_sync_q[1];

  // Result drawn from the two-entry buffer one falling edge before the data edge.
  logic             buf_valid;
  logic [RES_W-1:0] buf_data;
  logic             buf_pop;

  gsr_buf #(
    .W (RES_W)
  ) u_buf (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (res_valid),
    .in_data   (res_data),
    .in_ready  (res_ready),
    .out_valid (buf_valid),
    .out_data  (buf_data),
    .out_ready (buf_pop)
  );

  // Applies the output coding to a straight binary result.
  function automatic logic [RES_W-1:0] apply_coding(input logic [RES_W-1:0] raw,
                                                    input logic            coding);
    apply_coding = raw;
    if (coding == CODE_TWOS) begin
      apply_coding[RES_W-1] = ~raw[RES_W-1];
    end
  endfunction

  gsr_state_t       st_q, st_d;
  logic [4:0]       edge_q, edge_d;
  logic [CFG_W-1:0] cfg_q, cfg_d;
  logic [CFG_W-1:0] sh_q, sh_d;
  logic [1:0]       mux_q, mux_d;
  logic             conv_cod_q, conv_cod_d;
  logic [15:0]      frame_q, frame_d;
  logic             dout_q, dout_d;
  logic             oe_q, oe_d;
  logic             start_q, start_d;
  logic             tick_q, tick_d;
  logic             pop_q, pop_d;
  logic [1:0]       new_ch;

  // Channel chosen for the next conversion: newly shifted bits if this is a write.
  assign new_ch  = sh_q[WRITE_BIT] ? sh_q[CHAN_SEL_HI:CHAN_SEL_LO]
                                   : cfg_q[CHAN_SEL_HI:CHAN_SEL_LO];
  assign buf_pop = pop_q;

  always_comb begin
    st_d       = st_q;
    edge_d     = edge_q;
    cfg_d      = cfg_q;
    sh_d       = sh_q;
    mux_d      = mux_q;
    conv_cod_d = conv_cod_q;
    frame_d    = frame_q;
    dout_d     = dout_q;
    oe_d       = oe_q;
    start_d    = 1'b0;
    tick_d     = 1'b0;
    pop_d      = 1'b0;
    unique case (st_q)
      ST_IDLE: begin
        if (cs_fall) begin
          // The conversion of this frame uses the channel already on the mux.
          st_d       = ST_XFER;
          edge_d     = 5'h00;
          sh_d       = '0;
          start_d    = 1'b1;
          conv_cod_d = cfg_q[CODING_BIT];
          frame_d    = {2'b00, mux_q, {RES_W{1'b0}}};
          dout_d     = 1'b0;
          oe_d       = 1'b1;
        end
      end
      ST_XFER: begin
        if (cs_high) begin
          // Released early: drop the partial word and undo a switched mux.
          st_d  = ST_IDLE;
          oe_d  = 1'b0;
          mux_d = cfg_q[CHAN_SEL_HI:CHAN_SEL_LO];
        end else if (sclk_fall) begin
          edge_d = edge_q + 5'h01;
          tick_d = 1'b1;
          if (edge_q < CFG_LAST_EDGE) begin
            sh_d = {sh_q[CFG_W-2:0], din_s};
          end
          // Bit n of the frame goes out just after falling edge n.
          frame_d = {frame_q[14:0], 1'b0};
          dout_d  = frame_q[14];
          if (edge_q + 5'h01 == DATA_EDGE - 5'h01) begin
            // Take the result now so it is in place before the data edge.
            pop_d = buf_valid;
            // The result MSB must sit at bit 14 so that it leaves on the data edge.
            frame_d[RES_W+2:3] = buf_valid ? apply_coding(buf_data, conv_cod_q)
                                           : {RES_W{1'b0}};
          end
          if (edge_q + 5'h01 == MUX_EDGE) begin
            mux_d = new_ch;
          end
          if (edge_q + 5'h01 == LAST_EDGE) begin
            oe_d = 1'b0;
            st_d = ST_TAIL;
            if (sh_q[WRITE_BIT]) begin
              cfg_d = sh_q;
            end
          end
        end
      end
      ST_TAIL: begin
        // Extra clocks after the sixteenth are ignored until chip select rises.
        if (cs_high) begin
          st_d = ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
        oe_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q       <= ST_IDLE;
      edge_q     <= 5'h00;
      cfg_q      <= CFG_RESET;
      sh_q       <= '0;
      mux_q      <= CFG_RESET[CHAN_SEL_HI:CHAN_SEL_LO];
      conv_cod_q <= CODE_TWOS;
      frame_q    <= 16'h0000;
      dout_q     <= 1'b0;
      oe_q       <= 1'b0;
      start_q    <= 1'b0;
      tick_q     <= 1'b0;
      pop_q      <= 1'b0;
    end else begin
      st_q       <= st_d;
      edge_q     <= edge_d;
      cfg_q      <= cfg_d;
      sh_q       <= sh_d;
      mux_q      <= mux_d;
      conv_cod_q <= conv_cod_d;
      frame_q    <= frame_d;
      dout_q     <= dout_d;
      oe_q       <= oe_d;
      start_q    <= start_d;
      tick_q     <= tick_d;
      pop_q      <= pop_d;
    end
  end

  assign dout_o     = dout_q;
  assign dout_oe    = oe_q;
  assign mux_sel    = mux_q;
  assign conv_start = start_q;
  assign conv_tick  = tick_q;

endmodule

/* verif/gsr_port_properties.sv */
// Concurrent checks on the serial port pins and converter controls.
`timescale 1ns/1ps
module gsr_port_properties
  import gsr_pkg::*;
(
  // Clock and reset.
  input wire logic             clk_sys,
  input wire logic             rst,
  // Serial pins.
  input wire logic             cs_n,
  input wire logic             sclk,
  input wire logic             din,
  input wire logic             dout_o,
  input wire logic             dout_oe,
  // Converter side.
  input wire logic [1:0]       mux_sel,
  input wire logic             conv_start,
  input wire logic             conv_tick,
  input wire logic             res_valid,
  input wire logic [RES_W-1:0] res_data,
  input wire logic             res_ready
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence cs_fall_s;
    $fell(cs_n);
  endsequence
  sequence oe_up_s;
    ##[1:6] ($rose(dout_oe) && !dout_o);
  endsequence

  frame_open_a: assert property (cs_fall_s |-> oe_up_s)
    else $error("output not enabled low after select fall");
  oe_release_a: assert property ($rose(cs_n) |-> ##[1:6] !dout_oe)
    else $error("output still driven after select rise");
  oe_drop_a: assert property ($fell(dout_oe) |->
    $past(cs_n, 2) || conv_tick || $past(conv_tick))
    else $error("output released without cause");
  start_pulse_a: assert property (conv_start |=> !conv_start)
    else $error("start pulse longer than one cycle");
  start_frame_a: assert property (conv_start |-> ##[0:1] dout_oe)
    else $error("start pulse outside a frame");
  tick_frame_a: assert property (conv_tick |-> !$past(cs_n, 3))
    else $error("converter tick outside a frame");
  dout_step_a: assert property (dout_oe && $past(dout_oe) && $changed(dout_o) |->
    conv_tick || $past(conv_tick))
    else $error("output bit changed away from a clock fall");
  mux_frame_a: assert property ($changed(mux_sel) |-> !$past(cs_n, 4))
    else $error("channel select changed outside a frame");
endmodule

/* verif/gsr_host.sv */
// Serial host model that frames transfers and samples the returned bits.
`timescale 1ns/1ps
module gsr_host (
  // Host-driven pins.
  output logic      cs_n,
  output logic      sclk,
  output logic      din,
  // Device output pin.
  input  wire logic dout_o,
  input  wire logic dout_oe
);
  logic last_v = 1'b0;
  logic line;

  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    din  = 1'b0;
  end

  // A released line shows the inverse of its last bit, so a stale value cannot pass.
  always @(dout_o or dout_oe) if (dout_oe) last_v = dout_o;
  assign line = dout_oe ? dout_o : ~last_v;

  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r, output logic oe);
    r = '0;
    cs_n = 1'b0;
    #40;
    for (int k = 0; k < n; k++) begin
      din = w[15-k];
      #40;
      r[15-k] = line;
      sclk = 1'b0;
      #40;
      sclk = 1'b1;
    end
    #40;
    oe = dout_oe;
    cs_n = 1'b1;
    #80;
  endtask
endmodule

/* verif/gsr_port_tb.sv */
// Bench for the serial port: host frames, converter stub and pin checks.
`timescale 1ns/1ps
module gsr_port_tb
  import gsr_pkg::*;
;
  logic             clk_sys = 1'b0;
  logic             rst = 1'b1;
  logic             cs_n, sclk, din, dout_o, dout_oe, conv_start, conv_tick, res_ready;
  logic [1:0]       mux_sel;
  logic             res_valid = 1'b0;
  logic [RES_W-1:0] res_data = 12'h000;
  logic [11:0]      val_q = 12'h1b7;
  logic [11:0]      cur, d;
  logic [15:0]      rd;
  logic             oe_end;
  logic [11:0]      exp_q[$];
  logic [11:0]      wds[7] = '{12'h000, 12'h871, 12'h8b0, 12'h8f1, 12'h030, 12'h831, 12'h000};
  int               lens[7] = '{16, 16, 16, 16, 16, 14, 16};
  int               err_total = 0;
  int               cmp_count = 0;
  int               cyc = 0;

  always #5 clk_sys = ~clk_sys;

  gsr_port dut_u (.clk_sys(clk_sys), .rst(rst), .cs_n(cs_n), .sclk(sclk), .din(din),
    .dout_o(dout_o), .dout_oe(dout_oe), .mux_sel(mux_sel), .conv_start(conv_start),
    .conv_tick(conv_tick), .res_valid(res_valid), .res_data(res_data), .res_ready(res_ready));
  gsr_host host_u (.cs_n(cs_n), .sclk(sclk), .din(din), .dout_o(dout_o), .dout_oe(dout_oe));

  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Holds the result offered until the buffer takes it at a clock edge.
  task automatic push(input logic [11:0] v);
    res_valid = 1'b1;
    res_data = v;
    while (res_ready !== 1'b1) @(posedge clk_sys) #1;
    @(posedge clk_sys) #1;
    exp_q.push_back(v);
    res_valid = 1'b0;
  endtask

  always @(posedge clk_sys) if (conv_start === 1'b1) begin
    #1;
    push(val_q);
    val_q = val_q + 12'h1b7;
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      wrap_up();
    end
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    push(12'h123);
    @(posedge clk_sys) #1;
    push(12'h456);
    chk("res_ready", res_ready, 1'b0);
    cur = CFG_RESET;
    // Frame table walks every channel, both codings, a skipped write and an abort.
    for (int i = 0; i < 7; i++) begin
      d = exp_q.pop_front();
      host_u.xfer({wds[i], 4'hf}, lens[i], rd, oe_end);
      if (lens[i] == 16) begin
        chk("frame", rd, {2'b00, cur[7:6], cur[0] ? d : {~d[11], d[10:0]}});
        chk("oe_end", oe_end, 1'b0);
        if (wds[i][11]) cur = wds[i];
      end else chk("oe_abort", dout_oe, 1'b0);
      chk("mux_sel", mux_sel, cur[7:6]);
    end
    wrap_up();
  end
endmodule

bind gsr_port gsr_port_properties chk_u (.clk_sys(clk_sys), .rst(rst), .cs_n(cs_n),
  .sclk(sclk), .din(din), .dout_o(dout_o), .dout_oe(dout_oe), .mux_sel(mux_sel),
  .conv_start(conv_start), .conv_tick(conv_tick), .res_valid(res_valid),
  .res_data(res_data), .res_ready(res_ready));
